// *** shared/ddrtc_pkg.sv ***
// shared constants, command codes and state layout of the sdram timing core
package ddrtc_pkg;
  localparam logic [7:0] OFS_TIMING1 = 8'h00;
  localparam logic [7:0] OFS_TIMING2 = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_IVAL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int T1_RP_POS = 28;
  localparam int T1_RAS_POS = 24;
  localparam int T1_RCD_POS = 20;
  localparam int T1_CL_POS = 16;
  localparam int T1_RFC_POS = 12;
  localparam int T1_WR_POS = 8;
  localparam int T1_RRD_POS = 4;
  localparam int T1_WTR_POS = 0;
  localparam int T2_RSD_POS = 24;
  localparam int T2_SHIFT_POS = 19;
  localparam int T2_WSD_POS = 10;
  localparam int CF_EN_POS = 31;
  localparam int CF_SR_POS = 30;
  localparam int CF_PD_POS = 21;
  localparam int CF_NO_CONCURRENT_AUTOPRECHARGE_POS = 17;
  localparam int CF_TWO_POS = 15;
  localparam int MD_EXT_POS = 16;
  localparam int MD_BASE_POS = 0;
  localparam int IV_REF_POS = 16;
  localparam int IV_PAGE_POS = 0;
  localparam int AP_BIT = 10;
  localparam int DLL_RST_BIT = 8;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [7:0] RFC_BASE_CYC = 8'h08;
  localparam logic [7:0] MRD_CYC = 8'h02;
  localparam logic [7:0] CNT_SAT = 8'hFF;
  localparam logic [5:0] HALF_SAT = 6'h3F;
  typedef enum logic [3:0] {
    PH_OFF = 4'b0000, PH_IPALL = 4'b0001, PH_IEMRS = 4'b0010,
    PH_IMRS = 4'b0011, PH_IPALL2 = 4'b0100, PH_IREF1 = 4'b0101,
    PH_IREF2 = 4'b0110, PH_IMRS2 = 4'b0111, PH_IDONE = 4'b1000,
    PH_READY = 4'b1001, PH_PDOWN = 4'b1010, PH_SREF = 4'b1011
  } ddrtc_phase_t;
  // ras, cas, we levels
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010,
    CMD_ACT = 3'b011, CMD_WR = 3'b100, CMD_RD = 3'b101, CMD_NOP = 3'b111
  } ddrtc_cmd_t;
  typedef struct packed {
    logic csN;
    ddrtc_cmd_t cmd;
    logic [1:0] ba;
    logic [13:0] addr;
  } ddrtc_pins_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] bank;
    logic [13:0] row;
    logic [10:0] col;
  } ddrtc_req_t;
  typedef struct packed {
    logic [31:0] tim1, tim2, ctrl, mode, ival, rdData;
    ddrtc_phase_t ph;
    ddrtc_pins_t pins;
    logic cke, hold, lastWr, refPend, ack, rdWin, rdBeat, dqsLvl;
    logic [3:0] bOpen;
    logic [3:0][13:0] bRow;
    logic [3:0][7:0] bAct;
    logic [3:0][15:0] bIdle;
    logic [7:0] sCmd, sPre, sAct, sRef, sWr, sRd;
    logic [13:0] refCnt;
    logic [5:0] rdHalf;
    logic [2:0] dqsS;
  } ddrtc_state_t;
endpackage

// *** verilog/ddrtc_core.sv ***
// sdram command timing, init, refresh and power control core
// Summary of operation
// - precharge to activate or refresh spacing
// - activate to precharge spacing per bank
// - activate to read or write spacing
// - read latency counted in half clocks
// - refresh to activate: eight plus field
// - write recovery before precharge
// - activate to activate spacing
// - last write data to read spacing
// - read strobe window in half steps
// - zero strobe delay means latency plus two half steps
// - address shift bit delays pins half clock
// - write strobe offset in quarter steps
// - zero write delay adds turnaround cycle
// - self refresh in sleep only when allowed
// - auto power down drops cke when idle
// - no concurrent autoprecharge blocks other accesses
// - two cycle mode holds address and control
// - init loads extended mode then mode
// - refresh issued every refresh period cycles
// - page held open, zero means autoprecharge
// - enable raises cke and runs init
// - address line ten carries autoprecharge flag
`timescale 1ns/10ps
module ddrtc_core import ddrtc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // access requests and power
  input wire ddrtc_req_t req,
  output logic reqAck,
  input wire logic sleepReq,
  // memory side
  input wire logic dqsIn,
  output ddrtc_pins_t memPins,
  output logic memCke,
  output logic addrHalfShift,
  output logic [2:0] wrStrobeDelay,
  output logic rdStrobeWin,
  output logic rdBeat
);
  ddrtc_state_t r, n;
  logic [7:0] tRp, tRas, tRcd, tRfc, tWr, tRrd, tWtr, blc, clc, wrEnd;
  logic [5:0] clHalf, rsdHalf;
  logic [15:0] pageHold;
  logic [13:0] refPer;
  logic en, srWant, pd, no_concurrent_autoprecharge, two, wsdZero, apMode, refDue;
  logic wrRecOk, preAllOk, rdOk, wrOk, actOk, idleAny, ncapBusy;
  logic [3:0] preOk, idleHit;
  logic [1:0] idleBank;
  logic issue;
  ddrtc_cmd_t ic;
  logic [1:0] iba;
  logic [13:0] iad;

  assign tRp = {5'h00, r.tim1[T1_RP_POS+:3]};
  assign tRas = {4'h0, r.tim1[T1_RAS_POS+:4]};
  assign tRcd = {5'h00, r.tim1[T1_RCD_POS+:3]};
  assign tRfc = RFC_BASE_CYC + {4'h0, r.tim1[T1_RFC_POS+:4]};
  assign tWr = {5'h00, r.tim1[T1_WR_POS+:3]};
  assign tRrd = {5'h00, r.tim1[T1_RRD_POS+:3]};
  assign tWtr = {5'h00, r.tim1[T1_WTR_POS+:3]};
  // code k means (k+1) half clocks, so code 7 is four clocks
  assign clHalf = {2'h0, r.tim1[T1_CL_POS+:3]} + 6'h01;
  assign clc = {3'h0, clHalf[5:1]} + {7'h00, clHalf[0]};
  assign rsdHalf = (r.tim2[T2_RSD_POS+:4] == 4'h0) ?
    clHalf + 6'h02 : {2'h0, r.tim2[T2_RSD_POS+:4]};
  assign wsdZero = (r.tim2[T2_WSD_POS+:3] == 3'h0);
  assign en = r.ctrl[CF_EN_POS];
  assign srWant = sleepReq && r.ctrl[CF_SR_POS];
  assign pd = r.ctrl[CF_PD_POS];
  assign no_concurrent_autoprecharge = r.ctrl[CF_NO_CONCURRENT_AUTOPRECHARGE_POS];
  assign two = r.ctrl[CF_TWO_POS];
  assign refPer = r.ival[IV_REF_POS+:14];
  assign pageHold = r.ival[IV_PAGE_POS+:16];
  assign apMode = (pageHold == 16'h0000);
  // burst of 2, 4 or 8 beats takes 1, 2 or 4 clocks
  assign blc = (r.mode[2:0] == 3'h1) ? 8'h01 :
    (r.mode[2:0] == 3'h3) ? 8'h04 : 8'h02;
  assign wrEnd = 8'h01 + blc;
  assign wrRecOk = r.sWr >= wrEnd + tWr;
  // an autoprecharge in flight blocks every access without concurrency
  assign ncapBusy = no_concurrent_autoprecharge && r.sPre < tRp;
  assign rdOk = r.bAct[req.bank] >= tRcd && r.sWr >= wrEnd + tWtr &&
    !ncapBusy && r.sWr >= wrEnd + {7'h00, wsdZero};
  assign wrOk = r.bAct[req.bank] >= tRcd && !ncapBusy &&
    r.sRd >= clc + blc + {7'h00, wsdZero};
  assign actOk = r.sPre >= tRp && r.sRef >= tRfc && r.sAct >= tRrd;
  assign refDue = en && refPer != 14'h0000 &&
    r.refCnt >= refPer - 14'h0001 && r.ph != PH_SREF;

  genvar g;
  for (g = 0; g < 4; g++) begin : gBank
    assign preOk[g] = r.bAct[g] >= tRas && wrRecOk;
    assign idleHit[g] = r.bOpen[g] && !apMode &&
      r.bIdle[g] >= pageHold;
  end
  assign preAllOk = &(preOk | ~r.bOpen);
  assign idleAny = |idleHit;

  function automatic logic [7:0] sat8(input logic [7:0] v);
    sat8 = (v == CNT_SAT) ? v : v + 8'h01;
  endfunction

  always_comb begin
    n = r;
    issue = 1'b0;
    ic = CMD_NOP;
    iba = 2'h0;
    iad = 14'h0000;
    idleBank = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (idleHit[i]) begin
        idleBank = 2'(i);
      end
    end
    n.ack = 1'b0;
    n.rdData = 32'h0000_0000;
    if (regWr) begin
      case (regAddr)
        OFS_TIMING1: n.tim1 = regWrData;
        OFS_TIMING2: n.tim2 = regWrData;
        OFS_CTRL: n.ctrl = regWrData;
        OFS_MODE: n.mode = regWrData;
        OFS_IVAL: n.ival = regWrData;
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFS_TIMING1: n.rdData = r.tim1;
        OFS_TIMING2: n.rdData = r.tim2;
        OFS_CTRL: n.rdData = r.ctrl;
        OFS_MODE: n.rdData = r.mode;
        OFS_IVAL: n.rdData = r.ival;
        OFS_STATUS: n.rdData = {22'h0, r.refPend, r.cke, r.bOpen, r.ph};
        default: n.rdData = 32'h0000_0000;
      endcase
    end
    n.sCmd = sat8(r.sCmd);
    n.sPre = sat8(r.sPre);
    n.sAct = sat8(r.sAct);
    n.sRef = sat8(r.sRef);
    n.sWr = sat8(r.sWr);
    n.sRd = sat8(r.sRd);
    for (int i = 0; i < 4; i++) begin
      n.bAct[i] = sat8(r.bAct[i]);
      if (r.bIdle[i] != 16'hFFFF) begin
        n.bIdle[i] = r.bIdle[i] + 16'h0001;
      end
    end
    n.refCnt = (refDue || !en) ? 14'h0000 : r.refCnt + 14'h0001;
    // first stage feeds only the second; a level counts once 2 and 3 agree
    n.dqsS = {r.dqsS[1:0], dqsIn};
    if (r.dqsS[1] == r.dqsS[2]) begin
      n.dqsLvl = r.dqsS[2];
    end
    n.rdBeat = r.rdWin && (n.dqsLvl != r.dqsLvl);
    if (r.rdHalf <= HALF_SAT - 6'h02) begin
      n.rdHalf = r.rdHalf + 6'h02;
    end
    // in two cycle mode the command lingers with chip select off
    n.hold = 1'b0;
    if (!r.hold) begin
      n.pins = '{csN: 1'b1, cmd: CMD_NOP, ba: 2'h0, addr: 14'h0000};
    end else begin
      n.pins.csN = 1'b1;
    end
    if (!en && r.ph != PH_OFF) begin
      n.ph = PH_OFF;
      n.cke = 1'b0;
      n.bOpen = 4'h0;
    end else if (!r.hold) begin
      unique case (r.ph)
        PH_OFF: begin
          if (en) begin
            n.cke = 1'b1;
            n.sCmd = 8'h01;
            n.ph = PH_IPALL;
          end
        end
        PH_IPALL, PH_IPALL2: begin
          if (r.sCmd >= MRD_CYC) begin
            issue = 1'b1;
            ic = CMD_PRE;
            iad[AP_BIT] = 1'b1;
            n.ph = (r.ph == PH_IPALL) ? PH_IEMRS : PH_IREF1;
          end
        end
        PH_IEMRS: begin
          if (r.sPre >= tRp) begin
            issue = 1'b1;
            ic = CMD_MRS;
            iba = r.mode[MD_EXT_POS+12+:2];
            iad = {2'h0, r.mode[MD_EXT_POS+:12]};
            n.ph = PH_IMRS;
          end
        end
        PH_IMRS, PH_IMRS2: begin
          if (r.sCmd >= MRD_CYC && r.sRef >= tRfc) begin
            issue = 1'b1;
            ic = CMD_MRS;
            iba = r.mode[MD_BASE_POS+12+:2];
            iad = {2'h0, r.mode[MD_BASE_POS+:12]};
            iad[DLL_RST_BIT] = (r.ph == PH_IMRS);
            n.ph = (r.ph == PH_IMRS) ? PH_IPALL2 : PH_IDONE;
          end
        end
        PH_IREF1, PH_IREF2: begin
          if (r.sPre >= tRp && r.sRef >= tRfc) begin
            issue = 1'b1;
            ic = CMD_REF;
            n.ph = (r.ph == PH_IREF1) ? PH_IREF2 : PH_IMRS2;
          end
        end
        PH_IDONE: begin
          if (r.sCmd >= MRD_CYC) begin
            n.ph = PH_READY;
          end
        end
        PH_READY: begin
          if (r.refPend || srWant) begin
            if (|r.bOpen) begin
              if (preAllOk) begin
                issue = 1'b1;
                ic = CMD_PRE;
                iad[AP_BIT] = 1'b1;
              end
            end else if (r.sPre >= tRp && r.sRef >= tRfc) begin
              issue = 1'b1;
              ic = CMD_REF;
              if (!r.refPend) begin
                n.cke = 1'b0;
                n.ph = PH_SREF;
              end
            end
          end else if (idleAny) begin
            if (preOk[idleBank]) begin
              issue = 1'b1;
              ic = CMD_PRE;
              iba = idleBank;
            end
          end else if (req.valid && !r.ack) begin
            iba = req.bank;
            if (!r.bOpen[req.bank]) begin
              if (actOk) begin
                issue = 1'b1;
                ic = CMD_ACT;
                iad = req.row;
              end
            end else if (r.bRow[req.bank] != req.row) begin
              if (preOk[req.bank]) begin
                issue = 1'b1;
                ic = CMD_PRE;
              end
            end else if (req.write ? wrOk : rdOk) begin
              issue = 1'b1;
              ic = req.write ? CMD_WR : CMD_RD;
              // column skips line ten, which carries the close flag
              iad = {2'h0, req.col[10], apMode, req.col[9:0]};
            end
          end else if (pd && r.sRd > clc + blc && r.sWr > wrEnd) begin
            n.cke = 1'b0;
            n.ph = PH_PDOWN;
          end
        end
        PH_PDOWN: begin
          if (req.valid || r.refPend || !pd) begin
            n.cke = 1'b1;
            n.ph = PH_READY;
          end
        end
        PH_SREF: begin
          if (!srWant) begin
            n.cke = 1'b1;
            n.sRef = 8'h01;
            n.ph = PH_READY;
          end
        end
        default: begin
          n.ph = PH_OFF;
          n.cke = 1'b0;
        end
      endcase
    end
    if (issue) begin
      n.pins = '{csN: 1'b0, cmd: ic, ba: iba, addr: iad};
      n.hold = two;
      n.sCmd = 8'h01;
      unique case (ic)
        CMD_ACT: begin
          n.sAct = 8'h01;
          n.bAct[iba] = 8'h01;
          n.bOpen[iba] = 1'b1;
          n.bRow[iba] = iad;
          n.bIdle[iba] = 16'h0000;
        end
        CMD_PRE: begin
          n.sPre = 8'h01;
          if (iad[AP_BIT]) begin
            n.bOpen = 4'h0;
          end else begin
            n.bOpen[iba] = 1'b0;
          end
        end
        CMD_REF: begin
          n.sRef = 8'h01;
          n.refPend = 1'b0;
        end
        CMD_RD, CMD_WR: begin
          n.ack = 1'b1;
          n.bIdle[iba] = 16'h0000;
          n.lastWr = (ic == CMD_WR);
          if (ic == CMD_WR) begin
            n.sWr = 8'h01;
          end else begin
            n.sRd = 8'h01;
            n.rdHalf = 6'h02;
          end
          if (iad[AP_BIT]) begin
            n.bOpen[iba] = 1'b0;
            n.sPre = 8'h01;
          end
        end
        default: ;
      endcase
    end
    // a refresh falling due as one is issued stays pending
    if (refDue) begin
      n.refPend = 1'b1;
    end
    n.rdWin = n.rdHalf >= rsdHalf &&
      n.rdHalf < rsdHalf + {blc[4:0], 1'b0};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{ph: PH_OFF,
        pins: '{csN: 1'b1, cmd: CMD_NOP, ba: 2'h0, addr: 14'h0000},
        bAct: {4{CNT_SAT}}, sCmd: CNT_SAT, sPre: CNT_SAT, sAct: CNT_SAT,
        sRef: CNT_SAT, sWr: CNT_SAT, sRd: CNT_SAT, rdHalf: HALF_SAT,
        default: '0};
    end else begin
      r <= n;
    end
  end

  assign regRdData = r.rdData;
  assign reqAck = r.ack;
  assign memPins = r.pins;
  assign memCke = r.cke;
  assign addrHalfShift = r.tim2[T2_SHIFT_POS];
  assign wrStrobeDelay = r.tim2[T2_WSD_POS+:3];
  assign rdStrobeWin = r.rdWin;
  assign rdBeat = r.rdBeat;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire nAct = issue && ic == CMD_ACT;
  wire nPre = issue && ic == CMD_PRE;
  wire nRw = issue && (ic == CMD_RD || ic == CMD_WR);

  property p_pre_act; nAct |-> r.sPre >= tRp; endproperty
  a_pre_act: assert property (p_pre_act) else $error("act too soon");
  property p_act_pre; nPre && !iad[AP_BIT] |-> r.bAct[iba] >= tRas;
  endproperty
  a_act_pre: assert property (p_act_pre) else $error("pre early");
  property p_act_rw; nRw |-> r.bAct[iba] >= tRcd; endproperty
  a_act_rw: assert property (p_act_rw) else $error("access early");
  property p_no_concurrent_autoprecharge; nRw && no_concurrent_autoprecharge |-> r.sPre >= tRp; endproperty
  a_no_concurrent_autoprecharge: assert property (p_no_concurrent_autoprecharge) else $error("no_concurrent_autoprecharge overlap");
  property p_ref_act; nAct |-> r.sRef >= tRfc; endproperty
  a_ref_act: assert property (p_ref_act) else $error("trfc broken");
  property p_wr_pre; nPre |-> r.sWr >= wrEnd + tWr; endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("twr broken");
  property p_act_act; nAct |-> r.sAct >= tRrd; endproperty
  a_act_act: assert property (p_act_act) else $error("trrd broken");
  property p_wr_rd; issue && ic == CMD_RD |-> r.sWr >= wrEnd + tWtr;
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("twtr broken");
  property p_two; !memPins.csN && two |=> memPins.csN &&
    $stable(memPins.cmd) && $stable(memPins.addr); endproperty
  a_two: assert property (p_two) else $error("no hold");
  property p_ap; nRw |=> memPins.addr[AP_BIT] == apMode; endproperty
  a_ap: assert property (p_ap) else $error("ap flag");
  property p_pdown; r.ph == PH_PDOWN |-> !memCke ##1 1'b1; endproperty
  a_pdown: assert property (p_pdown) else $error("cke high");
  property p_en; r.ph == PH_OFF && en |=> memCke && r.ph == PH_IPALL;
  endproperty
  a_en: assert property (p_en) else $error("no init");
  c_act: cover property (nAct ##[1:20] nRw);
  c_ref: cover property (r.ph == PH_READY && issue && ic == CMD_REF);
  c_pd: cover property (r.ph == PH_PDOWN ##1 r.ph == PH_READY);
  c_sr: cover property (r.ph == PH_SREF);
endmodule

// *** bench/ddrtc_mem_model.sv ***
// far-side memory model: answers each read seen while idle with a strobe burst
`timescale 1ns/10ps
module ddrtc_mem_model import ddrtc_pkg::*; (
  // clock
  input wire logic sys_clk,
  // pins from the controller
  input wire ddrtc_pins_t memPins,
  input wire logic memCke,
  // extra cycles before the strobe, zero for a prompt answer
  input wire logic [3:0] slowCyc,
  // strobe back to the controller
  output logic dqsIn
);
  initial begin
    dqsIn = 1'h0;
    forever begin
      @(posedge sys_clk);
      if (memCke === 1'h1 && memPins.csN === 1'h0 &&
          memPins.cmd === CMD_RD) begin
        repeat (slowCyc) @(posedge sys_clk);
        // four strobe edges at link rate, then the released line flips
        repeat (5) #24 dqsIn = ~dqsIn;
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the sdram timing core
`timescale 1ns/10ps
module tb_top import ddrtc_pkg::*; ;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic sleepReq = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] regRdData;
  ddrtc_req_t req = '0;
  ddrtc_pins_t memPins, prevP;
  logic reqAck, dqsIn, memCke, addrHalfShift, rdStrobeWin, rdBeat;
  logic [2:0] wrStrobeDelay;
  logic [3:0] slowCyc = 4'h0;
  logic [3:0] bOpen = 4'h0;
  logic prevCmd = 1'h0;
  logic prevWin = 1'h0;
  logic two = 1'h0;
  int badCount = 0;
  int nCompared = 0;
  int cyc = 0;
  int rp, ras, rcd, cl, rfc, wrc, rrd, wtr, pi, refGap;
  int lastPre = -99, lastRef = -99, lastActAny = -99, lastWrAny = -99;
  int lastAct[4] = '{default: -99};
  int lastWr[4] = '{default: -99};
  ddrtc_pins_t q[$];
  logic [7:0] ofs[6] = '{OFS_TIMING1, OFS_TIMING2, OFS_CTRL, OFS_MODE,
    OFS_IVAL, OFS_STATUS};
  ddrtc_cmd_t ic[7] = '{CMD_PRE, CMD_MRS, CMD_MRS, CMD_PRE, CMD_REF,
    CMD_REF, CMD_MRS};

  ddrtc_core u_ddrtc_core (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .req(req), .reqAck(reqAck),
    .sleepReq(sleepReq), .dqsIn(dqsIn), .memPins(memPins),
    .memCke(memCke), .addrHalfShift(addrHalfShift),
    .wrStrobeDelay(wrStrobeDelay), .rdStrobeWin(rdStrobeWin),
    .rdBeat(rdBeat));
  ddrtc_mem_model u_ddrtc_mem_model (.sys_clk(sys_clk),
    .memPins(memPins), .memCke(memCke), .slowCyc(slowCyc),
    .dqsIn(dqsIn));

  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] t1();
    return {1'h0, 3'(rp), 4'(ras), 1'h0, 3'(rcd), 1'h0, 3'(cl),
      4'(rfc), 1'h0, 3'(wrc), 1'h0, 3'(rrd), 1'h0, 3'(wtr)};
  endfunction
  function automatic logic [31:0] ctl(input logic sr, pd, tw);
    return {1'h1, sr, 4'h0, 2'h2, 2'h0, pd, 5'h0, tw, 15'h0};
  endfunction

  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic sp(input string nm, input int gap, lo);
    chk(nm, 32'(gap >= lo), 32'h1);
  endtask
  // a gap cycle after each strobe keeps two drives out of one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge sys_clk);
    regWr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge sys_clk);
    regRd <= 1'h0;
    @(posedge sys_clk);
    d = regRdData;
  endtask
  task automatic acc(input logic w, input logic [1:0] b,
      input logic [13:0] r, input logic [10:0] c, output int t);
    int n = 0;
    req <= {1'h1, w, b, r, c};
    do begin
      @(posedge sys_clk);
      n++;
    end while (reqAck !== 1'h1 && n < 400);
    req <= '0;
    t = int'($time);
    chk("ack", 32'(reqAck), 32'h1);
    @(posedge sys_clk);
  endtask
  task automatic traf(input int k);
    int t;
    repeat (k) begin
      slowCyc <= 4'($urandom);
      acc(1'($urandom), 2'($urandom), 14'($urandom % 3),
        11'($urandom), t);
    end
  endtask
  task automatic wc(input logic v);
    int n = 0;
    while (memCke !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("cke", 32'(memCke), 32'(v));
  endtask
  task automatic rdWin(output int d);
    int t;
    repeat (30) @(posedge sys_clk);
    acc(1'h0, 2'h0, 14'h5, 11'h3, t);
    d = 1;
    while (rdStrobeWin !== 1'h1 && d < 40) begin
      @(posedge sys_clk);
      d++;
    end
  endtask
  task automatic rdwr(output int g);
    int t0, t1;
    repeat (30) @(posedge sys_clk);
    acc(1'h0, 2'h2, 14'h1, 11'h4, t0);
    acc(1'h1, 2'h2, 14'h1, 11'h8, t1);
    g = t1 - t0;
  endtask

  // pin monitor: spacings are counted edge to edge on chip-select low
  always @(posedge sys_clk) begin
    logic [1:0] b;
    cyc++;
    if (cyc > 60000) begin
      badCount++;
      summarize();
    end
    b = memPins.ba;
    if (prevCmd && two)
      chk("hold", 32'(memPins), 32'({1'h1, prevP[18:0]}));
    else if (prevCmd)
      chk("single", 32'(!memPins.csN || memPins.cmd === CMD_NOP),
        32'h1);
    if (reqAck === 1'h1)
      chk("access", 32'(memPins), 32'({1'h0, req.write ? CMD_WR :
        CMD_RD, req.bank, 2'h0, req.col[10], pi == 0,
        req.col[9:0]}));
    if (rdBeat === 1'h1)
      chk("beat", 32'(prevWin), 32'h1);
    prevWin = rdStrobeWin;
    prevCmd = memPins.csN === 1'h0;
    prevP = memPins;
    if (prevCmd) begin
      if (q.size() < 8)
        q.push_back(memPins);
      case (memPins.cmd)
        CMD_ACT: begin
          sp("rp", cyc - lastPre, rp);
          sp("rfc", cyc - lastRef, 8 + rfc);
          sp("rrd", cyc - lastActAny, rrd);
          lastAct[b] = cyc;
          lastActAny = cyc;
          bOpen[b] = 1'h1;
        end
        CMD_REF: begin
          sp("rpref", cyc - lastPre, rp);
          refGap = cyc - lastRef;
          lastRef = cyc;
        end
        CMD_PRE: begin
          for (int i = 0; i < 4; i++)
            if (bOpen[i] && (memPins.addr[10] || i == b)) begin
              sp("ras", cyc - lastAct[i], ras);
              sp("wrec", cyc - lastWr[i], 3 + wrc);
              bOpen[i] = 1'h0;
            end
          lastPre = cyc;
        end
        CMD_RD, CMD_WR: begin
          sp("rcd", cyc - lastAct[b], rcd);
          if (memPins.cmd === CMD_RD)
            sp("wtr", cyc - lastWrAny, 3 + wtr);
          else begin
            lastWr[b] = cyc;
            lastWrAny = cyc;
          end
          // auto precharge restarts the precharge timer at the command
          if (memPins.addr[10]) begin
            bOpen[b] = 1'h0;
            lastPre = cyc;
          end
        end
        default: ;
      endcase
    end
  end

  initial begin
    logic [31:0] d, e;
    int d0, d1, d2, d3, g0, g1, r, n;
    void'($urandom(32'h4C2D));
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      chk("rstval", d, REG_RESET);
    end
    for (int i = 0; i < 5; i++) begin
      // enable stays clear until the whole setup is in place
      e = $urandom & (i == 2 ? 32'h7FFF_FFFF : 32'hFFFF_FFFF);
      wr(ofs[i], e);
      rd(ofs[i], d);
      chk("rdback", d, e);
    end
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, d);
    chk("status", d, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, d);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      e = $urandom & 32'h0F08_1C00;
      wr(OFS_TIMING2, e);
      repeat (2) @(posedge sys_clk);
      chk("shift", 32'(addrHalfShift), 32'(e[19]));
      chk("wsd", 32'(wrStrobeDelay), 32'(e[12:10]));
    end
    rp = 2 + $urandom % 6;
    ras = 4 + $urandom % 12;
    rcd = 1 + $urandom % 7;
    cl = 3;
    rfc = 1 + $urandom % 15;
    wrc = 1 + $urandom % 7;
    rrd = 1 + $urandom % 4;
    wtr = 1 + $urandom % 7;
    pi = 0;
    wr(OFS_TIMING1, t1());
    wr(OFS_TIMING2, 32'h0000_0400);
    wr(OFS_MODE, 32'h1000_0022);
    wr(OFS_IVAL, 32'h3FFF_0000);
    q.delete();
    wr(OFS_CTRL, ctl(1'h0, 1'h0, 1'h0));
    // cke rises on the edge after the enable lands
    @(posedge sys_clk);
    chk("ckeon", 32'(memCke), 32'h1);
    n = 0;
    while (q.size() < 7 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    for (int i = 0; i < 7; i++)
      chk("initcmd", 32'(q[i].cmd), 32'(ic[i]));
    chk("pall", 32'(q[0].addr[10] & q[3].addr[10]), 32'h1);
    chk("emrs", 32'({q[1].ba, q[1].addr}), 32'h4000);
    chk("mrs", 32'({q[2].ba, q[2].addr}), 32'h0122);
    chk("mrsend", 32'({q[6].ba, q[6].addr}), 32'h0022);
    n = 0;
    do begin
      rd(OFS_STATUS, d);
      n++;
    end while (d[3:0] !== 4'h9 && n < 100);
    chk("ready", 32'(d[3:0]), 32'h9);
    wr(OFS_IVAL, 32'h012C_0000);
    traf(40);
    repeat (1000) @(posedge sys_clk);
    chk("refresh_period", refGap, 300);
    wr(OFS_IVAL, 32'h3FFF_0014);
    pi = 20;
    repeat (320) @(posedge sys_clk);
    traf(30);
    acc(1'h0, 2'h1, 14'h7, 11'h0, r);
    rd(OFS_STATUS, d);
    chk("pgopen", 32'(d[5]), 32'h1);
    repeat (30) @(posedge sys_clk);
    rd(OFS_STATUS, d);
    chk("pgshut", 32'(d[5]), 32'h0);
    rdWin(d0);
    wr(OFS_TIMING2, 32'h0600_0400);
    rdWin(d1);
    wr(OFS_TIMING2, 32'h0800_0400);
    rdWin(d2);
    wr(OFS_TIMING2, 32'h0000_0400);
    cl = 5;
    wr(OFS_TIMING1, t1());
    rdWin(d3);
    cl = 3;
    wr(OFS_TIMING1, t1());
    chk("rsdzero", d1, d0);
    chk("rsdhalf", d2, d0 + 1);
    chk("latency", d3, d0 + 1);
    rdwr(g1);
    wr(OFS_TIMING2, 32'h0);
    rdwr(g0);
    chk("turn", g0, g1 + 4);
    wr(OFS_CTRL, ctl(1'h0, 1'h1, 1'h0));
    wc(1'h0);
    acc(1'h1, 2'h3, 14'h2, 11'h1, r);
    chk("ckeup", 32'(memCke), 32'h1);
    wr(OFS_CTRL, ctl(1'h0, 1'h0, 1'h0));
    wc(1'h1);
    sleepReq <= 1'h1;
    n = 0;
    repeat (60) begin
      @(posedge sys_clk);
      n += int'(memCke !== 1'h1);
    end
    chk("nosref", n, 0);
    sleepReq <= 1'h0;
    wr(OFS_CTRL, ctl(1'h1, 1'h0, 1'h0));
    r = lastRef;
    sleepReq <= 1'h1;
    wc(1'h0);
    // let the pin monitor log the refresh before looking
    @(posedge sys_clk);
    chk("sref", 32'(lastRef != r), 32'h1);
    sleepReq <= 1'h0;
    traf(3);
    repeat (40) @(posedge sys_clk);
    wr(OFS_CTRL, ctl(1'h0, 1'h0, 1'h1) | 32'h0002_0000);
    two = 1'h1;
    traf(20);
    summarize();
  end
endmodule
